// ### hdl/csfr_params.svh
// offsets, field positions, reset values and masks of the core sfr bank
`ifndef CSFR_PARAMS_SVH
`define CSFR_PARAMS_SVH

// ****************************************
// register addresses
// ****************************************
`define CSFR_ADDR_ACCUM   8'hE0
`define CSFR_ADDR_SECOND  8'hF0
`define CSFR_ADDR_STACK   8'h81
`define CSFR_ADDR_PTR_LO  8'h82
`define CSFR_ADDR_PTR_HI  8'h83
`define CSFR_ADDR_PWR     8'h87
`define CSFR_ADDR_FLAGS   8'hD0

// ****************************************
// reset values
// ****************************************
`define CSFR_RST_ACCUM    8'h00
`define CSFR_RST_SECOND   8'h00
`define CSFR_RST_STACK    8'h07
`define CSFR_RST_PTR      8'h00
`define CSFR_RST_PWR      8'h00
`define CSFR_RST_FLAGS    8'h00

// ****************************************
// cpu flags word fields
// ****************************************
`define CSFR_FLG_CARRY    7
`define CSFR_FLG_HALF     6
`define CSFR_FLG_USER_A   5
`define CSFR_FLG_BANK_HI  4
`define CSFR_FLG_BANK_LO  3
`define CSFR_FLG_WRAP     2
`define CSFR_FLG_USER_B   1
`define CSFR_FLG_PARITY   0

// ****************************************
// power control fields
// ****************************************
`define CSFR_PWR_DOUBLER  7
`define CSFR_PWR_SPI_WAKE 6
`define CSFR_PWR_EXT_WAKE 5
`define CSFR_PWR_SPARE1   3
`define CSFR_PWR_SPARE0   2
`define CSFR_PWR_DOWN     1
`define CSFR_PWR_SLEEP    0
`define CSFR_PWR_WMASK    8'hEF

// ****************************************
// misc
// ****************************************
`define CSFR_BIT_BYTE_MASK 8'hF8
`define CSFR_UNMAPPED_READ 8'h00

`endif

// ### hdl/csfr_pkg.sv
// types shared by the core sfr bank modules
package csfr_pkg;

   typedef enum logic [3:0] {
      CSFR_OP_ADD,
      CSFR_OP_ADDC,
      CSFR_OP_SUBB,
      CSFR_OP_MUL,
      CSFR_OP_DIV,
      CSFR_OP_AND,
      CSFR_OP_OR,
      CSFR_OP_XOR,
      CSFR_OP_NOT,
      CSFR_OP_CLR
   } csfr_op_type;

   typedef struct packed {
      logic [7:0]  accum;
      logic [7:0]  second;
      logic [7:0]  stack;
      logic [7:0]  ptr_lo;
      logic [7:0]  ptr_hi;
      logic [7:0]  flags;
      logic [7:0]  pwr;
      logic [7:0]  rdata;
      logic        bit_rdata;
      logic [7:0]  ram_addr;
      logic [7:0]  ram_data;
      logic        ram_wr;
      logic [7:0]  bank_base;
   } csfr_state_type;

endpackage

// ### hdl/csfr_alu_if.sv
// operand and result carrier between the sfr bank and its math unit
`timescale 1ns/1ps
interface csfr_alu_if;
   csfr_pkg::csfr_op_type op;
   logic [7:0]            accum;
   logic [7:0]            second;
   logic [7:0]            operand;
   logic                  carry_in;
   logic [7:0]            res_accum;
   logic [7:0]            res_second;
   logic                  wr_second;
   logic                  carry;
   logic                  half;
   logic                  wrap;
   logic                  upd_carry;
   logic                  upd_half;
   logic                  upd_wrap;

   modport core (
      output op, accum, second, operand, carry_in,
      input  res_accum, res_second, wr_second, carry, half, wrap,
      input  upd_carry, upd_half, upd_wrap
   );
   modport unit (
      input  op, accum, second, operand, carry_in,
      output res_accum, res_second, wr_second, carry, half, wrap,
      output upd_carry, upd_half, upd_wrap
   );
endinterface

// ### hdl/csfr_alu.sv
// combinational math unit working on accumulator and second operand
`timescale 1ns/1ps
module csfr_alu (
   csfr_alu_if.unit m
);

   always_comb begin
      logic [8:0]  wide;
      logic [4:0]  nib;
      logic [15:0] prod;
      logic        cin;
      wide         = 9'h000;
      nib          = 5'h00;
      prod         = 16'h0000;
      cin          = 1'b0;
      m.res_accum  = m.accum;
      m.res_second = m.second;
      m.wr_second  = 1'b0;
      m.carry      = 1'b0;
      m.half       = 1'b0;
      m.wrap       = 1'b0;
      m.upd_carry  = 1'b0;
      m.upd_half   = 1'b0;
      m.upd_wrap   = 1'b0;
      case (m.op)
         csfr_pkg::CSFR_OP_ADD, csfr_pkg::CSFR_OP_ADDC: begin
            cin         = (m.op == csfr_pkg::CSFR_OP_ADDC) ? m.carry_in : 1'b0;
            wide        = {1'b0, m.accum} + {1'b0, m.operand} + {8'h00, cin};
            nib         = {1'b0, m.accum[3:0]} + {1'b0, m.operand[3:0]} + {4'h0, cin};
            m.res_accum = wide[7:0];
            m.carry     = wide[8];
            m.half      = nib[4];
            m.wrap      = (m.accum[7] == m.operand[7]) && (wide[7] != m.accum[7]);
            m.upd_carry = 1'b1;
            m.upd_half  = 1'b1;
            m.upd_wrap  = 1'b1;
         end
         csfr_pkg::CSFR_OP_SUBB: begin
            wide        = {1'b0, m.accum} - {1'b0, m.operand} - {8'h00, m.carry_in};
            nib         = {1'b0, m.accum[3:0]} - {1'b0, m.operand[3:0]} - {4'h0, m.carry_in};
            m.res_accum = wide[7:0];
            m.carry     = wide[8];
            m.half      = nib[4];
            m.wrap      = (m.accum[7] != m.operand[7]) && (wide[7] != m.accum[7]);
            m.upd_carry = 1'b1;
            m.upd_half  = 1'b1;
            m.upd_wrap  = 1'b1;
         end
         csfr_pkg::CSFR_OP_MUL: begin
            prod         = 16'(m.accum) * 16'(m.second);
            m.res_accum  = prod[7:0];
            m.res_second = prod[15:8];
            m.wr_second  = 1'b1;
            m.wrap       = |prod[15:8];
            m.upd_carry  = 1'b1;
            m.upd_wrap   = 1'b1;
         end
         csfr_pkg::CSFR_OP_DIV: begin
            // divide by zero leaves both operands untouched and flags the wrap
            if (m.second != 8'h00) begin
               m.res_accum  = m.accum / m.second;
               m.res_second = m.accum % m.second;
               m.wr_second  = 1'b1;
            end
            m.wrap      = (m.second == 8'h00);
            m.upd_carry = 1'b1;
            m.upd_wrap  = 1'b1;
         end
         csfr_pkg::CSFR_OP_AND: m.res_accum = m.accum & m.operand;
         csfr_pkg::CSFR_OP_OR:  m.res_accum = m.accum | m.operand;
         csfr_pkg::CSFR_OP_XOR: m.res_accum = m.accum ^ m.operand;
         csfr_pkg::CSFR_OP_NOT: m.res_accum = ~m.accum;
         csfr_pkg::CSFR_OP_CLR: m.res_accum = 8'h00;
         default: m.res_accum = m.accum;
      endcase
   end

endmodule

// ### hdl/csfr_core_sfr_bank.sv
// core special function register bank: math operands, stack, pointer, flags, power
//
// Notes on behaviour
// - accumulator is operand and result of math
// - second register pairs in multiply/divide, else scratch
// - push increments stack pointer, then writes RAM
// - stack pointer resets to 07H, first push 08H
// - pointer bytes separate, pair forms 16-bit address
// - flags word at D0H, reset 00H, bit addressable
// - power bit 7 doubles uart baud rate
// - power bit 6 lets spi wake power-down
// - power bit 5 ext irq zero wake; bit 4 reserved
// - power bits: down, sleep, two spares; 87H
// - all core registers live in sfr space
// - unoccupied addresses: no register, writes ignored
// - low 32 RAM bytes: four register banks
`timescale 1ns/1ps
`include "csfr_params.svh"
module csfr_core_sfr_bank (
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   input  wire logic [7:0]            sfr_addr,
   input  wire logic                  sfr_wr,
   input  wire logic                  sfr_rd,
   input  wire logic [7:0]            sfr_wdata,
   output logic      [7:0]            sfr_rdata,
   input  wire logic [7:0]            bit_addr,
   input  wire logic                  bit_wr,
   input  wire logic                  bit_rd,
   input  wire logic                  bit_wdata,
   output logic                       bit_rdata,
   input  wire logic                  alu_go,
   input  wire csfr_pkg::csfr_op_type alu_op,
   input  wire logic [7:0]            alu_operand,
   input  wire logic                  push_req,
   input  wire logic [7:0]            push_data,
   input  wire logic                  pop_req,
   input  wire logic                  ptr_inc,
   output logic      [7:0]            ram_wr_addr,
   output logic      [7:0]            ram_wr_data,
   output logic                       ram_wr,
   output logic      [7:0]            accumulator,
   output logic      [7:0]            stack_top_pointer,
   output logic      [15:0]           memory_pointer,
   output logic      [7:0]            cpu_flags_word,
   output logic      [7:0]            bank_base,
   output logic                       uart_rate_doubler,
   output logic                       spi_wake_enable,
   output logic                       ext_irq_zero_wake_enable,
   output logic                       power_down_request,
   output logic                       sleep_core_request
);

   csfr_pkg::csfr_state_type st;
   csfr_pkg::csfr_state_type next_st;
   csfr_alu_if               alu_bus ();

   // ****************************************
   // register read decode
   // ****************************************
   // unoccupied addresses read as a fixed value, software must not rely on it
   function automatic logic [7:0] sfr_read(input logic [7:0] a,
                                           input csfr_pkg::csfr_state_type s);
      case (a)
         `CSFR_ADDR_ACCUM:  sfr_read = s.accum;
         `CSFR_ADDR_SECOND: sfr_read = s.second;
         `CSFR_ADDR_STACK:  sfr_read = s.stack;
         `CSFR_ADDR_PTR_LO: sfr_read = s.ptr_lo;
         `CSFR_ADDR_PTR_HI: sfr_read = s.ptr_hi;
         `CSFR_ADDR_FLAGS:  sfr_read = s.flags;
         `CSFR_ADDR_PWR:    sfr_read = s.pwr;
         default:           sfr_read = `CSFR_UNMAPPED_READ;
      endcase
   endfunction

   // ****************************************
   // register write decode
   // ****************************************
   function automatic csfr_pkg::csfr_state_type sfr_write(input logic [7:0] a,
                                                          input logic [7:0] d,
                                                          input csfr_pkg::csfr_state_type s);
      csfr_pkg::csfr_state_type r;
      r = s;
      case (a)
         `CSFR_ADDR_ACCUM:  r.accum  = d;
         `CSFR_ADDR_SECOND: r.second = d;
         `CSFR_ADDR_STACK:  r.stack  = d;
         `CSFR_ADDR_PTR_LO: r.ptr_lo = d;
         `CSFR_ADDR_PTR_HI: r.ptr_hi = d;
         `CSFR_ADDR_FLAGS:  r.flags  = d;
         `CSFR_ADDR_PWR:    r.pwr    = d & `CSFR_PWR_WMASK;
         default:           r        = s;
      endcase
      sfr_write = r;
   endfunction

   // only the flags word, accumulator and second register bytes are bit addressable
   function automatic logic bit_ok(input logic [7:0] a);
      bit_ok = ((a & `CSFR_BIT_BYTE_MASK) == `CSFR_ADDR_FLAGS) ||
               ((a & `CSFR_BIT_BYTE_MASK) == `CSFR_ADDR_ACCUM) ||
               ((a & `CSFR_BIT_BYTE_MASK) == `CSFR_ADDR_SECOND);
   endfunction

   // ****************************************
   // math unit
   // ****************************************
   assign alu_bus.op       = alu_op;
   assign alu_bus.accum    = st.accum;
   assign alu_bus.second   = st.second;
   assign alu_bus.operand  = alu_operand;
   assign alu_bus.carry_in = st.flags[`CSFR_FLG_CARRY];

   csfr_alu u_alu (
      .m (alu_bus.unit)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [7:0] byte_a;
      logic [7:0] byte_v;
      logic [15:0] ptr;
      next_st        = st;
      next_st.ram_wr = 1'b0;
      byte_a         = bit_addr & `CSFR_BIT_BYTE_MASK;
      byte_v         = sfr_read(byte_a, st);
      ptr            = {st.ptr_hi, st.ptr_lo};

      // reads see the value before any update of this cycle
      if (sfr_rd) begin
         next_st.rdata = sfr_read(sfr_addr, st);
      end
      if (bit_rd) begin
         next_st.bit_rdata = bit_ok(bit_addr) ? byte_v[bit_addr[2:0]] : 1'b0;
      end

      if (alu_go) begin
         next_st.accum = alu_bus.res_accum;
         if (alu_bus.wr_second) begin
            next_st.second = alu_bus.res_second;
         end
         if (alu_bus.upd_carry) begin
            next_st.flags[`CSFR_FLG_CARRY] = alu_bus.carry;
         end
         if (alu_bus.upd_half) begin
            next_st.flags[`CSFR_FLG_HALF] = alu_bus.half;
         end
         if (alu_bus.upd_wrap) begin
            next_st.flags[`CSFR_FLG_WRAP] = alu_bus.wrap;
         end
      end

      if (push_req) begin
         next_st.stack    = st.stack + 8'h01;
         next_st.ram_addr = st.stack + 8'h01;
         next_st.ram_data = push_data;
         next_st.ram_wr   = 1'b1;
      end else if (pop_req) begin
         next_st.stack = st.stack - 8'h01;
      end

      if (ptr_inc) begin
         ptr            = ptr + 16'h0001;
         next_st.ptr_hi = ptr[15:8];
         next_st.ptr_lo = ptr[7:0];
      end

      // a software write lands after the math, stack and pointer updates, so it wins over them
      if (sfr_wr) begin
         next_st = sfr_write(sfr_addr, sfr_wdata, next_st);
      end
      if (bit_wr && bit_ok(bit_addr)) begin
         byte_v                 = sfr_read(byte_a, next_st);
         byte_v[bit_addr[2:0]]  = bit_wdata;
         next_st                = sfr_write(byte_a, byte_v, next_st);
      end

      // parity always tracks the accumulator, it cannot be written
      next_st.flags[`CSFR_FLG_PARITY] = ^next_st.accum;
      next_st.bank_base = {3'b000, next_st.flags[`CSFR_FLG_BANK_HI:`CSFR_FLG_BANK_LO],
                           3'b000};
   end

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st.accum     <= `CSFR_RST_ACCUM;
         st.second    <= `CSFR_RST_SECOND;
         st.stack     <= `CSFR_RST_STACK;
         st.ptr_lo    <= `CSFR_RST_PTR;
         st.ptr_hi    <= `CSFR_RST_PTR;
         st.flags     <= `CSFR_RST_FLAGS;
         st.pwr       <= `CSFR_RST_PWR;
         st.rdata     <= 8'h00;
         st.bit_rdata <= 1'b0;
         st.ram_addr  <= 8'h00;
         st.ram_data  <= 8'h00;
         st.ram_wr    <= 1'b0;
         st.bank_base <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign sfr_rdata                = st.rdata;
   assign bit_rdata                = st.bit_rdata;
   assign ram_wr_addr              = st.ram_addr;
   assign ram_wr_data              = st.ram_data;
   assign ram_wr                   = st.ram_wr;
   assign accumulator              = st.accum;
   assign stack_top_pointer        = st.stack;
   assign memory_pointer           = {st.ptr_hi, st.ptr_lo};
   assign cpu_flags_word           = st.flags;
   assign bank_base                = st.bank_base;
   assign uart_rate_doubler        = st.pwr[`CSFR_PWR_DOUBLER];
   assign spi_wake_enable          = st.pwr[`CSFR_PWR_SPI_WAKE];
   assign ext_irq_zero_wake_enable = st.pwr[`CSFR_PWR_EXT_WAKE];
   assign power_down_request       = st.pwr[`CSFR_PWR_DOWN];
   assign sleep_core_request       = st.pwr[`CSFR_PWR_SLEEP];

endmodule

// ### verif/csfr_core_sfr_bank_chk.sv
// port-level assertions for the core sfr bank
`timescale 1ns/1ps
`include "csfr_params.svh"
module csfr_core_sfr_bank_chk (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_wdata,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        bit_wr,
   input wire logic        alu_go,
   input wire logic        push_req,
   input wire logic [7:0]  push_data,
   input wire logic        pop_req,
   input wire logic        ptr_inc,
   input wire logic [7:0]  ram_wr_addr,
   input wire logic [7:0]  ram_wr_data,
   input wire logic        ram_wr,
   input wire logic [7:0]  accumulator,
   input wire logic [7:0]  stack_top_pointer,
   input wire logic [15:0] memory_pointer,
   input wire logic [7:0]  cpu_flags_word,
   input wire logic [7:0]  bank_base,
   input wire logic        uart_rate_doubler,
   input wire logic        spi_wake_enable,
   input wire logic        ext_irq_zero_wake_enable,
   input wire logic        power_down_request,
   input wire logic        sleep_core_request
);
   logic quiet;
   // other sources may legally move registers, so only a lone write is judged
   assign quiet = !(alu_go || push_req || pop_req || ptr_inc || bit_wr);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_stack_reset_load: assert property ($rose(resetn) |-> stack_top_pointer == 8'h07)
      else $error("stack pointer not 07 after reset");
   a_push_then_write: assert property (push_req && !sfr_wr |=> ram_wr &&
      ram_wr_addr == $past(stack_top_pointer) + 8'h01 && ram_wr_addr == stack_top_pointer
      && ram_wr_data == $past(push_data)) else $error("push order wrong");
   a_ram_wr_cause: assert property (ram_wr |-> $past(push_req))
      else $error("ram write without push");
   a_parity_tracks: assert property (cpu_flags_word[0] == ^accumulator)
      else $error("parity bit wrong");
   a_bank_decode: assert property ($stable(cpu_flags_word) |->
      bank_base == {3'h0, cpu_flags_word[4:3], 3'h0}) else $error("bank base wrong");
   a_power_bits: assert property (sfr_wr && sfr_addr == `CSFR_ADDR_PWR |=>
      {uart_rate_doubler, spi_wake_enable, ext_irq_zero_wake_enable, power_down_request,
      sleep_core_request} == {$past(sfr_wdata[7:5]), $past(sfr_wdata[1:0])})
      else $error("power bits wrong");
   a_ptr_increment: assert property (ptr_inc && !sfr_wr |=>
      memory_pointer == $past(memory_pointer) + 16'h0001) else $error("pointer inc wrong");
   a_flags_write: assert property (sfr_wr && sfr_addr == `CSFR_ADDR_FLAGS && quiet |=>
      cpu_flags_word[7:1] == $past(sfr_wdata[7:1])) else $error("flags write lost");
   a_unmapped_ignored: assert property (sfr_wr && quiet && !(sfr_addr inside {8'hE0, 8'hF0,
      8'h81, 8'h82, 8'h83, 8'h87, 8'hD0}) |=> $stable(accumulator) && $stable(memory_pointer)
      && $stable(stack_top_pointer) && $stable(cpu_flags_word)) else $error("unmapped write hit");
   a_accum_readback: assert property (sfr_rd && sfr_addr == `CSFR_ADDR_ACCUM |=>
      sfr_rdata == $past(accumulator)) else $error("accumulator read wrong");
endmodule
bind csfr_core_sfr_bank csfr_core_sfr_bank_chk i_chk (.ref_clk(ref_clk), .resetn(resetn),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
   .sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .alu_go(alu_go), .push_req(push_req),
   .push_data(push_data), .pop_req(pop_req), .ptr_inc(ptr_inc), .ram_wr_addr(ram_wr_addr),
   .ram_wr_data(ram_wr_data), .ram_wr(ram_wr), .accumulator(accumulator),
   .stack_top_pointer(stack_top_pointer), .memory_pointer(memory_pointer),
   .cpu_flags_word(cpu_flags_word), .bank_base(bank_base),
   .uart_rate_doubler(uart_rate_doubler), .spi_wake_enable(spi_wake_enable),
   .ext_irq_zero_wake_enable(ext_irq_zero_wake_enable),
   .power_down_request(power_down_request), .sleep_core_request(sleep_core_request));

// ### verif/csfr_core_sfr_bank_bench.sv
// self-checking bench for the core sfr bank
`timescale 1ns/1ps
`include "csfr_params.svh"
module csfr_core_sfr_bank_bench;
   logic        ref_clk, resetn, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, alu_go;
   logic        push_req, pop_req, ptr_inc, ram_wr, bit_rdata, up, uw, ew, dn, sl;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, bit_addr, alu_operand, push_data, rv;
   logic [7:0]  ram_wr_addr, ram_wr_data, accumulator, stack_top_pointer, cpu_flags_word;
   logic [7:0]  bank_base;
   logic [15:0] memory_pointer;
   logic [7:0]  m [0:255];
   logic [7:0]  regs [7] = '{8'hE0, 8'hF0, 8'h81, 8'h82, 8'h83, 8'h87, 8'hD0};
   logic [31:0] seed = 32'h8C5E;
   int          miscompares, n_compared;
   csfr_pkg::csfr_op_type alu_op;
   csfr_core_sfr_bank i_csfr_core_sfr_bank (.ref_clk(ref_clk), .resetn(resetn),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd),
      .bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .alu_go(alu_go), .alu_op(alu_op),
      .alu_operand(alu_operand), .push_req(push_req), .push_data(push_data),
      .pop_req(pop_req), .ptr_inc(ptr_inc), .ram_wr_addr(ram_wr_addr),
      .ram_wr_data(ram_wr_data), .ram_wr(ram_wr), .accumulator(accumulator),
      .stack_top_pointer(stack_top_pointer), .memory_pointer(memory_pointer),
      .cpu_flags_word(cpu_flags_word), .bank_base(bank_base), .uart_rate_doubler(up),
      .spi_wake_enable(uw), .ext_irq_zero_wake_enable(ew), .power_down_request(dn),
      .sleep_core_request(sl));
   // ****************************************
   // helpers and model
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic step;
      @(posedge ref_clk);
      #5;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // parity is hardware-owned, so the model derives it instead of storing it
   function automatic logic [7:0] expd(input logic [7:0] a);
      if (a == 8'hD0) return {m[a][7:1], ^m[8'hE0]};
      if (a == 8'h87) return m[a] & 8'hEF;
      return (a inside {regs}) ? m[a] : 8'h00;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      step;
      sfr_wr = 1'b0;
      m[a] = d;
      // idle edge keeps back-to-back calls from toggling the strobe in one step
      step;
   endtask
   task automatic rd(input logic [7:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      step;
      sfr_rd = 1'b0;
      check(sfr_rdata, expd(a));
      step;
   endtask
   task automatic rd_all;
      foreach (regs[i]) rd(regs[i]);
      check({accumulator, stack_top_pointer, cpu_flags_word}, {m[8'hE0], m[8'h81], expd(8'hD0)});
      check(memory_pointer, {m[8'h83], m[8'h82]});
      check({up, uw, ew, dn, sl}, {m[8'h87][7:5], m[8'h87][1:0]});
   endtask
   task automatic alu(input csfr_pkg::csfr_op_type op, input logic [7:0] o);
      int          ur, hr, sr;
      logic [15:0] p;
      logic [7:0]  a, b, f;
      logic        ci;
      a = m[8'hE0];
      b = m[8'hF0];
      f = m[8'hD0];
      // carry only feeds the with-carry and borrow forms
      ci = (op inside {csfr_pkg::CSFR_OP_ADDC, csfr_pkg::CSFR_OP_SUBB}) ? f[7] : 1'b0;
      ur = int'(a) + int'(o) + int'(ci);
      hr = int'(a[3:0]) + int'(o[3:0]) + int'(ci);
      sr = $signed(a) + $signed(o) + int'(ci);
      if (op == csfr_pkg::CSFR_OP_SUBB) begin
         ur = int'(a) - int'(o) - int'(ci);
         hr = int'(a[3:0]) - int'(o[3:0]) - int'(ci);
         sr = $signed(a) - $signed(o) - int'(ci);
      end
      p = a * b;
      alu_op = op;
      alu_operand = o;
      alu_go = 1'b1;
      step;
      alu_go = 1'b0;
      case (op)
         csfr_pkg::CSFR_OP_ADD, csfr_pkg::CSFR_OP_ADDC, csfr_pkg::CSFR_OP_SUBB: begin
            m[8'hE0] = 8'(ur);
            f[7] = (ur > 255) || (ur < 0);
            f[6] = (hr > 15) || (hr < 0);
            f[2] = (sr > 127) || (sr < -128);
         end
         csfr_pkg::CSFR_OP_MUL: begin
            {m[8'hF0], m[8'hE0]} = p;
            f[7] = 1'b0;
            f[2] = p[15:8] != 8'h00;
         end
         csfr_pkg::CSFR_OP_DIV: begin
            f[7] = 1'b0;
            f[2] = b == 8'h00;
            if (b != 8'h00) begin
               m[8'hE0] = a / b;
               m[8'hF0] = a % b;
            end
         end
         csfr_pkg::CSFR_OP_AND: m[8'hE0] = a & o;
         csfr_pkg::CSFR_OP_OR:  m[8'hE0] = a | o;
         csfr_pkg::CSFR_OP_NOT: m[8'hE0] = ~a;
         csfr_pkg::CSFR_OP_CLR: m[8'hE0] = 8'h00;
         default: m[8'hE0] = a ^ o;
      endcase
      m[8'hD0] = f;
      check({accumulator, cpu_flags_word}, {m[8'hE0], expd(8'hD0)});
      rd(8'hF0);
   endtask
   task automatic tally_and_finish;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #3000000;
      miscompares++;
      tally_and_finish;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {resetn, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, alu_go, push_req, pop_req} = '0;
      {ptr_inc, sfr_addr, sfr_wdata, bit_addr, alu_operand, push_data} = '0;
      alu_op = csfr_pkg::CSFR_OP_ADD;
      foreach (regs[i]) m[regs[i]] = 8'h00;
      m[8'h81] = 8'h07;
      repeat (8) @(posedge ref_clk);
      #5 resetn = 1'b1;
      rd_all;
      push_req = 1'b1;
      push_data = rnd();
      rv = push_data;
      step;
      check({ram_wr, ram_wr_addr, ram_wr_data}, {8'h01, 8'h08, rv});
      push_data = rnd();
      rv = push_data;
      step;
      check({ram_wr, ram_wr_addr, ram_wr_data}, {8'h01, 8'h09, rv});
      push_req = 1'b0;
      pop_req = 1'b1;
      step;
      pop_req = 1'b0;
      check({ram_wr, stack_top_pointer}, {1'b0, 8'h08});
      m[8'h81] = 8'h08;
      wr(8'h87, 8'hFF);
      rd_all;
      repeat (6) foreach (regs[i]) wr(regs[i], rnd());
      rd_all;
      repeat (30) begin
         rv = rnd();
         if (!(rv inside {regs})) begin
            wr(rv, rnd());
            rd(rv);
         end
      end
      rd_all;
      wr(8'h83, 8'hFF);
      wr(8'h82, 8'hFE);
      ptr_inc = 1'b1;
      step;
      step;
      ptr_inc = 1'b0;
      {m[8'h83], m[8'h82]} = 16'h0000;
      rd_all;
      for (int b = 0; b < 4; b++) begin
         wr(8'hD0, 8'(b << 3));
         step;
         check(bank_base, 8'(b << 3));
      end
      wr(8'hD0, 8'h00);
      for (int b = 0; b < 8; b++) begin
         bit_addr = 8'hD0 + 8'(b);
         bit_wdata = 1'b1;
         bit_wr = 1'b1;
         step;
         bit_wr = 1'b0;
         bit_rd = 1'b1;
         m[8'hD0][b] = 1'b1;
         check(cpu_flags_word, expd(8'hD0));
         step;
         bit_rd = 1'b0;
         rv = expd(8'hD0);
         check(bit_rdata, rv[b]);
      end
      // the power byte is not bit addressable, so a bit read gives zero
      bit_addr = 8'h87;
      step;
      bit_rd = 1'b1;
      step;
      bit_rd = 1'b0;
      check(bit_rdata, 1'b0);
      repeat (6) begin
         wr(8'hE0, rnd());
         wr(8'hF0, rnd());
         alu(csfr_pkg::CSFR_OP_ADD, rnd());
         alu(csfr_pkg::CSFR_OP_ADDC, rnd());
         alu(csfr_pkg::CSFR_OP_SUBB, rnd());
         alu(csfr_pkg::CSFR_OP_MUL, m[8'hF0]);
         alu(csfr_pkg::CSFR_OP_DIV, m[8'hF0]);
         alu(csfr_pkg::CSFR_OP_AND, rnd());
         alu(csfr_pkg::CSFR_OP_OR, rnd());
         alu(csfr_pkg::CSFR_OP_XOR, rnd());
         alu(csfr_pkg::CSFR_OP_NOT, rnd());
      end
      alu(csfr_pkg::CSFR_OP_CLR, rnd());
      wr(8'hF0, 8'h00);
      alu(csfr_pkg::CSFR_OP_DIV, 8'h00);
      rd_all;
      tally_and_finish;
   end
endmodule
